// ===== rtl/rcb_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Two 128-byte banks, each reached only through its own index and data ports.
// [R2] Top index of either bank reaches one shared control byte.
// [R3] Bank 0 holds clock, control and spare bytes; bank 1 spare bytes.
// [R4] Activate bit 0 enables bank 0 ports; clear means no response.
// [R5] Activate bit 1 enables bank 1 ports independently; other bits reserved.
// [R6] Bank 0 base from 0x60 (bits 11-8) and 0x61 (bits 7-1), low resets 0x70.
// [R7] Bank 1 base from 0x62 and 0x63, low byte resets 0x74.
// [R8] Last bank 0 index write is readable at config index 0xF1.
// [R9] Index port sits exactly at the bank base address.
// [R10] Data port at base plus one for bank 0, plus two for bank 1.
// [R11] Index bit 7 is ignored when choosing the storage byte.
// [R12] All four index and data ports read and write.
// [R13] Host and microcontroller may both use the ports.
// [R14] Clock interrupt drives its own active-low pin.
// [R15] Register C is read-only; register D bit 7 set only by reading D.
// [R16] Index write latches selector; data accesses use the latched byte.
// [R17] Full twelve-bit compare; respond only when bank is active.
module rcb_top (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic hard_rst_i,
   input wire logic soft_rst_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic [11:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   input wire logic mcu_req_i,
   input wire logic mcu_wr_i,
   input wire logic [11:0] mcu_addr_i,
   input wire logic [7:0] mcu_wdata_i,
   output logic host_ack_o,
   output logic mcu_ack_o,
   output logic [7:0] acc_rdata_o,
   output logic acc_hit_o,
   input wire logic cfg_rd_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_index_i,
   input wire logic [7:0] cfg_wdata_i,
   output logic [7:0] cfg_rdata_o,
   input wire logic clock_interrupt_line_i,
   output logic clock_irq_pin_n_o
);
   rcb_pkg::rcb_state_s st;
   rcb_pkg::rcb_state_s next_st;

   rcb_ram_if ram_bus ();

   logic host_sel;
   logic mcu_sel;
   logic acc_rd;
   logic acc_wr;
   logic [11:0] acc_addr;
   logic [7:0] acc_wdata;
   logic [11:0] base0;
   logic [11:0] base1;
   logic idx0_hit;
   logic data0_hit;
   logic idx1_hit;
   logic data1_hit;
   logic [6:0] sel_idx;
   logic sel_bank;

   assign base0 = {st.b0_high, st.b0_low};
   assign base1 = {st.b1_high, st.b1_low};

   rcb_port_decode #(
      .DATA_OFF(rcb_pkg::DATA0_OFFSET)
   ) u_dec0 (
      .addr_i(acc_addr),
      .base_i(base0),
      .enable_i(st.activate[rcb_pkg::ACT_BANK0]), // [R4]
      .index_hit_o(idx0_hit),
      .data_hit_o(data0_hit)
   );

   rcb_port_decode #(
      .DATA_OFF(rcb_pkg::DATA1_OFFSET)
   ) u_dec1 (
      .addr_i(acc_addr),
      .base_i(base1),
      .enable_i(st.activate[rcb_pkg::ACT_BANK1]), // [R5]
      .index_hit_o(idx1_hit),
      .data_hit_o(data1_hit)
   );

   rcb_cmos_ram u_ram (
      .mclk_i(mclk_i),
      .ram(ram_bus)
   );

   // Writable bits of a storage byte; read-only bits belong to the time core
   function automatic logic [7:0] write_mask(input logic bank, input logic [6:0] idx);
      logic [7:0] m;
      m = rcb_pkg::MASK_ALL;
      if (idx == rcb_pkg::SHARED_IDX) begin
         m = rcb_pkg::MASK_SHARED;
      end else if (!bank) begin
         case (idx)
            rcb_pkg::REG_A_IDX: m = rcb_pkg::MASK_REG_A;
            rcb_pkg::REG_B_IDX: m = rcb_pkg::MASK_REG_B;
            rcb_pkg::REG_C_IDX: m = rcb_pkg::MASK_NONE; // [R15]
            rcb_pkg::REG_D_IDX: m = rcb_pkg::MASK_REG_D; // [R15]
            default: m = rcb_pkg::MASK_ALL;
         endcase
      end
      return m;
   endfunction

   // Host strobes win; microcontroller holds its request until acknowledged
   always_comb begin
      host_sel = host_rd_i | host_wr_i; // [R13]
      mcu_sel = mcu_req_i & ~host_sel & ~st.mcu_ack; // [R13]
      acc_addr = host_sel ? host_addr_i : mcu_addr_i;
      acc_wdata = host_sel ? host_wdata_i : mcu_wdata_i;
      acc_wr = host_sel ? host_wr_i : (mcu_sel & mcu_wr_i);
      acc_rd = host_sel ? host_rd_i : (mcu_sel & ~mcu_wr_i);
   end

   always_comb begin
      next_st = st;
      next_st.host_ack = host_sel;
      next_st.mcu_ack = mcu_sel;
      next_st.irq_n = ~clock_interrupt_line_i; // [R14]

      // Data accesses use the selector latched by the last index write
      sel_bank = data1_hit; // [R1]
      sel_idx = data1_hit ? st.index1[6:0] : st.index0[6:0]; // [R11] [R16]
      if (sel_idx == rcb_pkg::SHARED_IDX) begin
         ram_bus.addr = {1'b0, sel_idx}; // [R2]
      end else begin
         ram_bus.addr = {sel_bank, sel_idx}; // [R1] [R3]
      end
      ram_bus.we = 1'b0;
      ram_bus.wdata = acc_wdata;
      ram_bus.wmask = rcb_pkg::MASK_NONE;

      if (acc_rd || acc_wr) begin
         next_st.acc_hit = idx0_hit | data0_hit | idx1_hit | data1_hit;
         next_st.acc_rdata = rcb_pkg::BYTE_ZERO;
      end

      if (acc_wr) begin
         if (idx0_hit) begin
            next_st.index0 = acc_wdata; // [R12] [R16]
            next_st.shadow = acc_wdata; // [R8]
         end else if (idx1_hit) begin
            next_st.index1 = acc_wdata; // [R12] [R16]
         end else if (data0_hit || data1_hit) begin
            ram_bus.we = 1'b1; // [R12]
            ram_bus.wmask = write_mask(sel_bank, sel_idx);
         end
      end else if (acc_rd) begin
         if (idx0_hit) begin
            next_st.acc_rdata = st.index0; // [R12]
         end else if (idx1_hit) begin
            next_st.acc_rdata = st.index1; // [R12]
         end else if (data0_hit || data1_hit) begin
            next_st.acc_rdata = ram_bus.rdata; // [R12]
            if (!sel_bank && sel_idx == rcb_pkg::REG_D_IDX) begin
               // Reading D returns the old value and then marks it valid
               ram_bus.we = 1'b1; // [R15]
               ram_bus.wdata = rcb_pkg::REG_D_VALID;
               ram_bus.wmask = rcb_pkg::REG_D_VALID;
            end
         end
      end

      // Configuration space
      if (cfg_rd_i) begin
         case (cfg_index_i)
            rcb_pkg::CFG_ACTIVATE: next_st.cfg_rdata = {6'h00, st.activate}; // [R5]
            rcb_pkg::CFG_B0_HIGH: next_st.cfg_rdata = {rcb_pkg::NIBBLE_ZERO, st.b0_high}; // [R6]
            rcb_pkg::CFG_B0_LOW: next_st.cfg_rdata = st.b0_low;
            rcb_pkg::CFG_B1_HIGH: next_st.cfg_rdata = {rcb_pkg::NIBBLE_ZERO, st.b1_high}; // [R7]
            rcb_pkg::CFG_B1_LOW: next_st.cfg_rdata = st.b1_low;
            rcb_pkg::CFG_SHADOW: next_st.cfg_rdata = st.shadow; // [R8]
            default: next_st.cfg_rdata = rcb_pkg::BYTE_ZERO;
         endcase
      end
      if (cfg_wr_i) begin
         case (cfg_index_i)
            rcb_pkg::CFG_ACTIVATE: next_st.activate = cfg_wdata_i[1:0]; // [R4] [R5]
            rcb_pkg::CFG_B0_HIGH: next_st.b0_high = cfg_wdata_i[3:0]; // [R6]
            rcb_pkg::CFG_B0_LOW: next_st.b0_low = cfg_wdata_i & rcb_pkg::LOW_BASE_MASK; // [R6]
            rcb_pkg::CFG_B1_HIGH: next_st.b1_high = cfg_wdata_i[3:0]; // [R7]
            rcb_pkg::CFG_B1_LOW: next_st.b1_low = cfg_wdata_i & rcb_pkg::LOW_BASE_MASK; // [R7]
            default: next_st.activate = st.activate;
         endcase
      end
      // Hard and soft reset restore the configuration and override a write
      if (hard_rst_i || soft_rst_i) begin
         next_st.activate = rcb_pkg::ACTIVATE_RST;
         next_st.b0_high = rcb_pkg::B0_HIGH_RST;
         next_st.b0_low = rcb_pkg::B0_LOW_RST; // [R6]
         next_st.b1_high = rcb_pkg::B1_HIGH_RST;
         next_st.b1_low = rcb_pkg::B1_LOW_RST; // [R7]
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st.activate <= rcb_pkg::ACTIVATE_RST;
         st.b0_high <= rcb_pkg::B0_HIGH_RST;
         st.b0_low <= rcb_pkg::B0_LOW_RST;
         st.b1_high <= rcb_pkg::B1_HIGH_RST;
         st.b1_low <= rcb_pkg::B1_LOW_RST;
         st.index0 <= rcb_pkg::INDEX_RST;
         st.index1 <= rcb_pkg::INDEX_RST;
         st.shadow <= rcb_pkg::INDEX_RST;
         st.acc_rdata <= rcb_pkg::BYTE_ZERO;
         st.acc_hit <= 1'b0;
         st.host_ack <= 1'b0;
         st.mcu_ack <= 1'b0;
         st.cfg_rdata <= rcb_pkg::BYTE_ZERO;
         st.irq_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign host_ack_o = st.host_ack;
   assign mcu_ack_o = st.mcu_ack;
   assign acc_rdata_o = st.acc_rdata;
   assign acc_hit_o = st.acc_hit;
   assign cfg_rdata_o = st.cfg_rdata;
   assign clock_irq_pin_n_o = st.irq_n;
endmodule

// ===== common/rcb_pkg.sv
package rcb_pkg;
   // Configuration register indices
   localparam logic [7:0] CFG_ACTIVATE = 8'h30;
   localparam logic [7:0] CFG_B0_HIGH = 8'h60;
   localparam logic [7:0] CFG_B0_LOW = 8'h61;
   localparam logic [7:0] CFG_B1_HIGH = 8'h62;
   localparam logic [7:0] CFG_B1_LOW = 8'h63;
   localparam logic [7:0] CFG_SHADOW = 8'hf1;
   // Reset values
   localparam logic [1:0] ACTIVATE_RST = 2'h0;
   localparam logic [3:0] B0_HIGH_RST = 4'h0;
   localparam logic [7:0] B0_LOW_RST = 8'h70;
   localparam logic [3:0] B1_HIGH_RST = 4'h0;
   localparam logic [7:0] B1_LOW_RST = 8'h74;
   localparam logic [7:0] INDEX_RST = 8'h00;
   // Field layout
   localparam int ACT_BANK0 = 0;
   localparam int ACT_BANK1 = 1;
   localparam logic [7:0] LOW_BASE_MASK = 8'hfe;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   // Data port offsets from each bank base
   localparam logic [11:0] DATA0_OFFSET = 12'h001;
   localparam logic [11:0] DATA1_OFFSET = 12'h002;
   // Storage locations with special access
   localparam logic [6:0] REG_A_IDX = 7'h0a;
   localparam logic [6:0] REG_B_IDX = 7'h0b;
   localparam logic [6:0] REG_C_IDX = 7'h0c;
   localparam logic [6:0] REG_D_IDX = 7'h0d;
   localparam logic [6:0] SHARED_IDX = 7'h7f;
   // Writable bit masks
   localparam logic [7:0] MASK_ALL = 8'hff;
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam logic [7:0] MASK_REG_A = 8'h7f;
   localparam logic [7:0] MASK_REG_B = 8'hfe;
   localparam logic [7:0] MASK_REG_D = 8'h3f;
   localparam logic [7:0] MASK_SHARED = 8'h01;
   localparam logic [7:0] REG_D_VALID = 8'h80;

   typedef struct packed {
      logic [1:0] activate;
      logic [3:0] b0_high;
      logic [7:0] b0_low;
      logic [3:0] b1_high;
      logic [7:0] b1_low;
      logic [7:0] index0;
      logic [7:0] index1;
      logic [7:0] shadow;
      logic [7:0] acc_rdata;
      logic acc_hit;
      logic host_ack;
      logic mcu_ack;
      logic [7:0] cfg_rdata;
      logic irq_n;
   } rcb_state_s;
endpackage

// ===== common/rcb_ram_if.sv
`timescale 1ns/10ps
interface rcb_ram_if;
   logic [7:0] addr;
   logic we;
   logic [7:0] wdata;
   logic [7:0] wmask;
   logic [7:0] rdata;
   modport ctrl (output addr, output we, output wdata, output wmask, input rdata);
   modport mem (input addr, input we, input wdata, input wmask, output rdata);
endinterface

// ===== rtl/rcb_port_decode.sv
`timescale 1ns/10ps
module rcb_port_decode #(
   parameter logic [11:0] DATA_OFF = 12'h001
) (
   input wire logic [11:0] addr_i,
   input wire logic [11:0] base_i,
   input wire logic enable_i,
   output logic index_hit_o,
   output logic data_hit_o
);
   logic [11:0] data_addr;
   // Wrap within the twelve-bit I/O space on purpose
   assign data_addr = 12'(base_i + DATA_OFF);
   // Full twelve-bit compare, gated by the bank activate bit
   assign index_hit_o = enable_i && (addr_i == base_i); // [R9] [R17]
   assign data_hit_o = enable_i && (addr_i == data_addr); // [R10] [R17]
endmodule

// ===== rtl/rcb_cmos_ram.sv
`timescale 1ns/10ps
module rcb_cmos_ram (
   input wire logic mclk_i,
   rcb_ram_if.mem ram
);
   // Battery-backed contents: no reset
   logic [7:0] mem [0:255];
   assign ram.rdata = mem[ram.addr];
   always_ff @(posedge mclk_i) begin
      if (ram.we) begin
         mem[ram.addr] <= (mem[ram.addr] & ~ram.wmask) | (ram.wdata & ram.wmask);
      end
   end
endmodule

// ===== testbench/rcb_top_monitor.sv
`timescale 1ns/10ps
module rcb_top_monitor (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic mcu_req_i,
   input wire logic host_ack_o,
   input wire logic mcu_ack_o,
   input wire logic [7:0] acc_rdata_o,
   input wire logic acc_hit_o,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_rdata_o,
   input wire logic clock_interrupt_line_i,
   input wire logic clock_irq_pin_n_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);
   a_host_ack: assert property ((host_rd_i || host_wr_i) |=> host_ack_o) else $error("host ack missing");
   a_ack_cause: assert property (host_ack_o |-> $past(host_rd_i) || $past(host_wr_i))
      else $error("host ack without strobe");
   a_mcu_take: assert property ((mcu_req_i && !host_rd_i && !host_wr_i && !mcu_ack_o) |=> mcu_ack_o)
      else $error("mcu ack missing");
   a_mcu_wait: assert property ((host_rd_i || host_wr_i) |=> !mcu_ack_o) else $error("mcu not held off");
   a_irq_pin: assert property (clock_irq_pin_n_o == !$past(clock_interrupt_line_i))
      else $error("irq pin wrong");
   a_miss_zero: assert property ((host_ack_o && !acc_hit_o) |-> acc_rdata_o == 8'h00)
      else $error("miss data not zero");
   a_wr_zero: assert property ((host_ack_o && $past(host_wr_i)) |-> acc_rdata_o == 8'h00)
      else $error("write data not zero");
   a_data_hold: assert property (!(host_ack_o || mcu_ack_o) |-> $stable(acc_rdata_o) && $stable(acc_hit_o))
      else $error("port result changed");
   a_cfg_hold: assert property (!$past(cfg_rd_i) |-> $stable(cfg_rdata_o)) else $error("cfg data changed");
endmodule

// ===== testbench/rcb_mcu_model.sv
`timescale 1ns/10ps
module rcb_mcu_model (
   input wire logic mclk_i,
   input wire logic mcu_ack_i,
   input wire logic [7:0] rdata_i,
   output logic mcu_req_o,
   output logic mcu_wr_o,
   output logic [11:0] mcu_addr_o,
   output logic [7:0] mcu_wdata_o
);
   int late = 0;
   initial begin
      mcu_req_o = 1'b0;
      mcu_wr_o = 1'b0;
      mcu_addr_o = 12'hfff;
      mcu_wdata_o = 8'hff;
   end
   // Request held until ack or 20 cycles, bus inverted once released
   task xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(negedge mclk_i);
      mcu_req_o = 1'b1;
      mcu_wr_o = wr;
      mcu_addr_o = a;
      mcu_wdata_o = d;
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
      end while (mcu_ack_i !== 1'b1 && n < 20);
      if (mcu_ack_i !== 1'b1) begin
         late++;
      end
      q = rdata_i;
      mcu_req_o = 1'b0;
      mcu_addr_o = ~a;
      mcu_wdata_o = ~d;
   endtask
endmodule

// ===== testbench/rcb_top_bench.sv
`timescale 1ns/10ps
module rcb_top_bench;
   logic mclk_i = 1'b0, arst_n_i = 1'b0, hard_rst_i = 1'b0, soft_rst_i = 1'b0;
   logic host_rd_i = 1'b0, host_wr_i = 1'b0, cfg_rd_i = 1'b0, cfg_wr_i = 1'b0, irq_line = 1'b0;
   logic [11:0] host_addr_i = 12'h000;
   logic [7:0] host_wdata_i = 8'h00, cfg_index_i = 8'h00, cfg_wdata_i = 8'h00, q;
   logic mcu_req_i, mcu_wr_i, host_ack_o, mcu_ack_o, acc_hit_o, clock_irq_pin_n_o;
   logic [11:0] mcu_addr_i;
   logic [7:0] mcu_wdata_i, acc_rdata_o, cfg_rdata_o;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   always #25 mclk_i = ~mclk_i;
   rcb_top rcb_top_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .hard_rst_i(hard_rst_i), .soft_rst_i(soft_rst_i),
      .host_rd_i(host_rd_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i),
      .mcu_req_i(mcu_req_i), .mcu_wr_i(mcu_wr_i), .mcu_addr_i(mcu_addr_i), .mcu_wdata_i(mcu_wdata_i),
      .host_ack_o(host_ack_o), .mcu_ack_o(mcu_ack_o), .acc_rdata_o(acc_rdata_o), .acc_hit_o(acc_hit_o),
      .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_index_i(cfg_index_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .clock_interrupt_line_i(irq_line), .clock_irq_pin_n_o(clock_irq_pin_n_o));
   rcb_mcu_model rcb_mcu_model_inst (.mclk_i(mclk_i), .mcu_ack_i(mcu_ack_o), .rdata_i(acc_rdata_o),
      .mcu_req_o(mcu_req_i), .mcu_wr_o(mcu_wr_i), .mcu_addr_o(mcu_addr_i), .mcu_wdata_o(mcu_wdata_i));
   task summarize;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
         error_cnt++;
      end
   endtask
   task hw(input logic [11:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      host_wr_i = 1'b1;
      host_addr_i = a;
      host_wdata_i = d;
      @(negedge mclk_i);
      host_wr_i = 1'b0;
      host_addr_i = ~a;
      chk("host ack", 8'h01, {7'h00, host_ack_o});
   endtask
   task rd(input logic [11:0] a);
      @(negedge mclk_i);
      host_rd_i = 1'b1;
      host_addr_i = a;
      @(negedge mclk_i);
      host_rd_i = 1'b0;
      host_addr_i = ~a;
   endtask
   task hr(input logic [11:0] a, input logic [7:0] e, input logic h);
      rd(a);
      chk("port data", e, acc_rdata_o);
      chk("port hit", {7'h00, h}, {7'h00, acc_hit_o});
   endtask
   task cw(input logic [7:0] i, input logic [7:0] d);
      @(negedge mclk_i);
      cfg_wr_i = 1'b1;
      cfg_index_i = i;
      cfg_wdata_i = d;
      @(negedge mclk_i);
      cfg_wr_i = 1'b0;
   endtask
   task cr(input logic [7:0] i, input logic [7:0] e);
      @(negedge mclk_i);
      cfg_rd_i = 1'b1;
      cfg_index_i = i;
      @(negedge mclk_i);
      cfg_rd_i = 1'b0;
      chk("config data", e, cfg_rdata_o);
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      arst_n_i = 1'b1;
      cr(8'h30, 8'h00);
      cr(8'h60, 8'h00);
      cr(8'h61, 8'h70);
      cr(8'h62, 8'h00);
      cr(8'h63, 8'h74);
      hw(12'h070, 8'h0e);
      hr(12'h071, 8'h00, 1'b0);
      cw(8'h30, 8'h01);
      hw(12'h070, 8'h8e);
      hr(12'h070, 8'h8e, 1'b1);
      hw(12'h071, 8'h5a);
      hr(12'h071, 8'h5a, 1'b1);
      hr(12'h074, 8'h00, 1'b0);
      cr(8'hf1, 8'h8e);
      cw(8'hf1, 8'h00);
      cr(8'hf1, 8'h8e);
      cw(8'h30, 8'hff);
      cr(8'h30, 8'h03);
      hw(12'h074, 8'h0e);
      hw(12'h076, 8'h33);
      hr(12'h076, 8'h33, 1'b1);
      hr(12'h075, 8'h00, 1'b0);
      hw(12'h070, 8'h0e);
      hr(12'h071, 8'h5a, 1'b1);
      hw(12'h070, 8'h7f);
      hw(12'h071, 8'h01);
      hw(12'h074, 8'hff);
      rd(12'h076);
      chk("shared bit", 8'h01, acc_rdata_o & 8'h01);
      rcb_mcu_model_inst.xfer(1'b1, 12'h070, 8'h0e, q);
      rcb_mcu_model_inst.xfer(1'b0, 12'h071, 8'h00, q);
      chk("mcu data", 8'h5a, q);
      chk("mcu ack late", 8'h00, rcb_mcu_model_inst.late[7:0]);
      cr(8'hf1, 8'h0e);
      cw(8'h60, 8'hf2);
      cr(8'h60, 8'h02);
      cw(8'h61, 8'ha5);
      cr(8'h61, 8'ha4);
      hr(12'h070, 8'h00, 1'b0);
      hr(12'h0a4, 8'h00, 1'b0);
      hw(12'h2a4, 8'h0e);
      hr(12'h2a5, 8'h5a, 1'b1);
      @(negedge mclk_i);
      hard_rst_i = 1'b1;
      @(negedge mclk_i);
      hard_rst_i = 1'b0;
      cr(8'h61, 8'h70);
      cr(8'h30, 8'h00);
      cw(8'h30, 8'h03);
      @(negedge mclk_i);
      soft_rst_i = 1'b1;
      @(negedge mclk_i);
      soft_rst_i = 1'b0;
      cr(8'h30, 8'h00);
      cw(8'h30, 8'h01);
      hw(12'h070, 8'h0d);
      hw(12'h071, 8'hff);
      rd(12'h071);
      chk("reg d writable", 8'h3f, acc_rdata_o & 8'h3f);
      rd(12'h071);
      chk("reg d valid", 8'hbf, acc_rdata_o & 8'hbf);
      irq_line = 1'b1;
      @(negedge mclk_i);
      chk("irq pin", 8'h00, {7'h00, clock_irq_pin_n_o});
      irq_line = 1'b0;
      summarize();
   end
endmodule
bind rcb_top rcb_top_monitor rcb_top_monitor_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .host_rd_i(host_rd_i),
   .host_wr_i(host_wr_i), .mcu_req_i(mcu_req_i), .host_ack_o(host_ack_o), .mcu_ack_o(mcu_ack_o),
   .acc_rdata_o(acc_rdata_o), .acc_hit_o(acc_hit_o), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
   .clock_interrupt_line_i(clock_interrupt_line_i), .clock_irq_pin_n_o(clock_irq_pin_n_o));
